/* verilog/spp_pkg.sv */
// Shared constants and arithmetic functions for the speech pre-processing block
package spp_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_LEN = 160;  // Samples per frame
  localparam int SUBSEG_LEN = 40;  // Samples per sub-segment
  localparam logic [7:0] FRAME_LAST = 8'h9F;  // Index of last sample in a frame
  localparam logic [5:0] SUBSEG_LAST = 6'h27;  // Index of last sample in a sub-segment

  // ****************************************************************
  // Numeric limits and filter constants
  // ****************************************************************
  localparam logic signed [15:0] S16_MAX = 16'sh7FFF;  // +32767
  localparam logic signed [15:0] S16_MIN = 16'sh8000;  // -32768
  localparam logic signed [31:0] S32_MAX = 32'sh7FFFFFFF;  // 2147483647
  localparam logic signed [31:0] S32_MIN = 32'sh80000000;  // -2147483648
  localparam logic signed [31:0] ROUND_HALF = 32'sh00004000;  // 16384, sign-extended
  localparam logic signed [15:0] POLE_COEF = 16'sh7FDF;  // 32735
  localparam int FRAC_SHIFT = 15;  // Fractional scaling
  localparam int DOWN_SHR = 3;  // Downscale right shift
  localparam int DOWN_SHL = 2;  // Downscale left shift
  localparam logic [15:0] HOME_PATTERN = 16'h0008;  // Homing sample value
  localparam logic [15:0] NONREC_RESET = 16'h0000;  // Reset value of delay state
  localparam logic [31:0] RECUR_RESET = 32'h00000000;  // Reset value of wide state

  // ****************************************************************
  // Pipeline state
  // ****************************************************************
  typedef enum logic [1:0] {SPP_IDLE, SPP_CALC, SPP_HOLD} spp_state_t;

  // ****************************************************************
  // Saturating 16-bit add
  // ****************************************************************
  function automatic logic signed [15:0] add16(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [16:0] s;
    s = 17'(a) + 17'(b);
    if (s > 17'sh07FFF) return S16_MAX;
    if (s < -17'sh08000) return S16_MIN;
    return s[15:0];
  endfunction

  // Saturating 16-bit subtract
  function automatic logic signed [15:0] sub16(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [16:0] s;
    s = 17'(a) - 17'(b);
    if (s > 17'sh07FFF) return S16_MAX;
    if (s < -17'sh08000) return S16_MIN;
    return s[15:0];
  endfunction

  // Saturating 32-bit add
  function automatic logic signed [31:0] add32(input logic signed [31:0] a, input logic signed [31:0] b);
    logic signed [32:0] s;
    s = 33'(a) + 33'(b);
    if (s[32] != s[31]) return s[32] ? S32_MIN : S32_MAX;
    return s[31:0];
  endfunction

  // Saturating 32-bit subtract
  function automatic logic signed [31:0] sub32(input logic signed [31:0] a, input logic signed [31:0] b);
    logic signed [32:0] s;
    s = 33'(a) - 33'(b);
    if (s[32] != s[31]) return s[32] ? S32_MIN : S32_MAX;
    return s[31:0];
  endfunction

  // Scaled fractional multiply, optional rounding
  function automatic logic signed [15:0] mult16(input logic signed [15:0] a, input logic signed [15:0] b,
                                                input logic rnd);
    logic signed [31:0] p;
    p = 32'(a) * 32'(b);
    if (a == S16_MIN && b == S16_MIN) return S16_MAX;
    if (rnd) p = p + ROUND_HALF;
    return 16'(p >>> FRAC_SHIFT);
  endfunction

  // Wide product with one-bit left shift
  function automatic logic signed [31:0] lmult(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [31:0] p;
    p = 32'(a) * 32'(b);
    return p <<< 1;
  endfunction

  // Absolute value with saturation of the most negative code
  function automatic logic signed [15:0] abs16(input logic signed [15:0] a);
    if (a == S16_MIN) return S16_MAX;
    return a[15] ? -a : a;
  endfunction

  // Signed shift: positive n shifts left, negative n shifts right
  function automatic logic signed [31:0] shl32(input logic signed [31:0] v, input logic signed [5:0] n);
    if (n < 0) return v >>> (-n);
    return v <<< n;
  endfunction

  // Signed shift: positive n shifts right, negative n shifts left
  function automatic logic signed [31:0] shr32(input logic signed [31:0] v, input logic signed [5:0] n);
    if (n < 0) return v <<< (-n);
    return v >>> n;
  endfunction

  // Sign-extend a short to a long
  function automatic logic signed [31:0] widen(input logic signed [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  // Keep the low half of a long
  function automatic logic signed [15:0] narrow(input logic signed [31:0] v);
    return v[15:0];
  endfunction

endpackage

/* verilog/spp_divider.sv */
// Sequential fractional divider, fifteen quotient bits
`timescale 1ns/1ps
module spp_divider (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [15:0] num,
  input wire logic [15:0] den,
  output logic busy,
  output logic done,
  output logic [15:0] quot
);

  // ****************************************************************
  // Restoring division state
  // ****************************************************************
  logic [16:0] rem_q;  // Partial remainder
  logic [15:0] den_q;  // Latched divisor
  logic [3:0] cnt_q;  // Bits still to produce
  logic run_q;  // Iteration in progress
  logic [16:0] rem_sh;  // Remainder doubled
  logic [16:0] rem_dif;  // Remainder minus divisor
  logic fit;  // Divisor fits

  assign rem_sh = {rem_q[15:0], 1'b0};
  assign rem_dif = rem_sh - {1'b0, den_q};
  assign fit = rem_sh >= {1'b0, den_q};
  assign busy = run_q;

  // Iterate one quotient bit per clock; equal operands end as 32767
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rem_q <= 17'h00000;
      den_q <= 16'h0000;
      cnt_q <= 4'h0;
      run_q <= 1'b0;
      done <= 1'b0;
      quot <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start && !run_q) begin
        rem_q <= {1'b0, num};
        den_q <= den;
        cnt_q <= 4'hF;
        run_q <= 1'b1;
        quot <= 16'h0000;
      end else if (run_q) begin
        rem_q <= fit ? rem_dif : rem_sh;
        quot <= {quot[14:0], fit};  // R6
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // Leading quotient bit is always clear
  quot_sign_a: assert property (@(posedge sys_clk) disable iff (sys_rst) done |-> !quot[15])  // R6
    else $error("divider quotient negative");

endmodule

/* verilog/spp_alu.sv */
// Combinational fixed-point primitive unit selected by an opcode
`timescale 1ns/1ps
module spp_alu (
  input wire logic [3:0] op,
  input wire logic signed [31:0] a,
  input wire logic signed [31:0] b,
  output logic signed [31:0] y
);

  // Select one primitive; short operands use the low halves
  always_comb begin
    unique case (op)
      4'h0: y = spp_pkg::widen(spp_pkg::add16(a[15:0], b[15:0]));  // R1
      4'h1: y = spp_pkg::widen(spp_pkg::sub16(a[15:0], b[15:0]));  // R2
      4'h2: y = spp_pkg::widen(spp_pkg::mult16(a[15:0], b[15:0], 1'b0));  // R3
      4'h3: y = spp_pkg::widen(spp_pkg::mult16(a[15:0], b[15:0], 1'b1));  // R4
      4'h4: y = spp_pkg::widen(spp_pkg::abs16(a[15:0]));  // R5
      4'h5: y = spp_pkg::lmult(a[15:0], b[15:0]);  // R7
      4'h6: y = spp_pkg::add32(a, b);  // R8
      4'h7: y = spp_pkg::sub32(a, b);  // R9
      4'h8: y = spp_pkg::shl32(a, b[5:0]);  // R10
      4'h9: y = spp_pkg::shr32(a, b[5:0]);  // R11
      4'hA: y = spp_pkg::widen(16'(spp_pkg::shl32(spp_pkg::widen(a[15:0]), b[5:0])));  // R10
      4'hB: y = spp_pkg::widen(16'(spp_pkg::shr32(spp_pkg::widen(a[15:0]), b[5:0])));  // R11
      4'hC: y = spp_pkg::widen(a[15:0]);  // R12
      4'hD: y = spp_pkg::widen(spp_pkg::narrow(a));  // R13
      default: y = 32'h00000000;
    endcase
  end

endmodule

/* verilog/spp_top.sv */
// Speech input pre-processing: downscale and offset-compensation filter
//
// How it works
// R1 - Short add saturates to the 16-bit range
// R2 - Short subtract saturates to the 16-bit range
// R3 - Fractional multiply, shift 15, min-squared saturates
// R4 - Rounding multiply adds 16384 before shifting
// R5 - Absolute value maps -32768 to 32767
// R6 - Divide gives positive 15-bit fraction, equal gives 32767
// R7 - Wide multiply returns product doubled
// R8 - Long add saturates to the 32-bit range
// R9 - Long subtract saturates to the 32-bit range
// R10 - Left shift; negative count shifts right
// R11 - Right shift; negative count shifts left
// R12 - Short to long sign-extends
// R13 - Long to short keeps low half
// R14 - Constants in long operations are sign-extended
// R15 - Frames of 160, sub-segments of 40
// R16 - Low three sample bits are ignored; the homing check still compares all 16 bits of in_sample
// R17 - Source sends left-justified 13-bit samples
// R18 - Downscale: shift right 3, left 2
// R19 - Difference term, then delay takes input
// R20 - Recursive term built by split multiply
// R21 - Output is rounded state shifted right 15
// R22 - Filter states persist, reset to zero
// R23 - Full homing frame clears both states afterwards
// R24 - One sample per handshake, frame end marked
`timescale 1ns/1ps
module spp_top #(
  parameter int FRAME_SAMPLES = spp_pkg::FRAME_LEN
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_sample,
  output logic out_frame_end,
  output logic out_subseg_end,
  input wire logic [3:0] alu_op,
  input wire logic [31:0] alu_a,
  input wire logic [31:0] alu_b,
  output logic [31:0] alu_y,
  input wire logic div_start,
  input wire logic [15:0] div_num,
  input wire logic [15:0] div_den,
  output logic div_busy,
  output logic div_done,
  output logic [15:0] div_quot
);

  // ****************************************************************
  // Primitive units offered to later encoder stages
  // ****************************************************************
  logic signed [31:0] alu_y_d;  // Combinational result

  spp_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .y(alu_y_d)
  );

  // Register the primitive result so data outputs come from flops
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alu_y <= 32'h00000000;
    end else begin
      alu_y <= alu_y_d;
    end
  end

  spp_divider u_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  // ****************************************************************
  // Filter state
  // ****************************************************************
  logic signed [15:0] nonrec_delay_state_q;  // Non-recursive delay
  logic signed [31:0] recursive_wide_state_q;  // Recursive wide state
  logic [7:0] idx_q;  // Sample position in the frame
  logic [5:0] sub_idx_q;  // Sample position in the sub-segment
  logic home_q;  // Every sample so far in this frame was the homing pattern
  logic out_valid_q;  // Output slot occupied
  logic [15:0] out_sample_q;  // Held output sample
  logic frame_end_q;  // Held frame-end flag
  logic subseg_end_q;  // Held sub-segment-end flag

  // ****************************************************************
  // Per-sample datapath, one sample per clock
  // ****************************************************************
  logic signed [15:0] masked;  // Sample with don't-care bits cleared
  logic signed [15:0] scaled;  // Downscaled input
  logic signed [15:0] difference_term;  // Non-recursive output
  logic signed [31:0] recursive_term;  // Recursive accumulator
  logic signed [15:0] msp;  // Upper part of the wide state
  logic signed [15:0] lsp;  // Lower remainder of the wide state
  logic signed [31:0] recur_next;  // Next wide state
  logic signed [15:0] filt_out;  // Filtered sample
  logic take;  // Input accepted this clock
  logic last;  // Accepted sample ends the frame
  logic homing_done;  // Accepted sample completes a homing frame

  always_comb begin
    masked = $signed({in_sample[15:3], 3'h0});  // R16
    scaled = 16'(spp_pkg::shl32(spp_pkg::shr32(spp_pkg::widen(masked), 6'(spp_pkg::DOWN_SHR)),
                                6'(spp_pkg::DOWN_SHL)));  // R18
    difference_term = spp_pkg::sub16(scaled, nonrec_delay_state_q);  // R19
    recursive_term = spp_pkg::shl32(spp_pkg::widen(difference_term), 6'(spp_pkg::FRAC_SHIFT));  // R20
    msp = spp_pkg::narrow(spp_pkg::shr32(recursive_wide_state_q, 6'(spp_pkg::FRAC_SHIFT)));  // R20
    lsp = spp_pkg::narrow(spp_pkg::sub32(recursive_wide_state_q,
                          spp_pkg::shl32(spp_pkg::widen(msp), 6'(spp_pkg::FRAC_SHIFT))));  // R20
    recursive_term = spp_pkg::add32(recursive_term,
                     spp_pkg::widen(spp_pkg::mult16(lsp, spp_pkg::POLE_COEF, 1'b1)));  // R20 R14
    recur_next = spp_pkg::add32(spp_pkg::shr32(spp_pkg::lmult(msp, spp_pkg::POLE_COEF), 6'h01),
                                recursive_term);  // R20
    filt_out = spp_pkg::narrow(spp_pkg::shr32(spp_pkg::add32(recur_next, spp_pkg::ROUND_HALF),
                               6'(spp_pkg::FRAC_SHIFT)));  // R21 R14
  end

  // Ready while the output slot is free or draining this clock
  assign in_ready = !out_valid_q || out_ready;  // R24
  assign take = in_valid && in_ready;  // R24
  assign last = idx_q == 8'(FRAME_SAMPLES - 1);  // R15
  assign homing_done = take && last && home_q && (in_sample == spp_pkg::HOME_PATTERN);  // R23

  // Filter states carry across frames; a complete homing frame zeroes them
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nonrec_delay_state_q <= spp_pkg::NONREC_RESET;  // R22
      recursive_wide_state_q <= spp_pkg::RECUR_RESET;  // R22
    end else if (homing_done) begin
      nonrec_delay_state_q <= spp_pkg::NONREC_RESET;  // R23
      recursive_wide_state_q <= spp_pkg::RECUR_RESET;  // R23
    end else if (take) begin
      nonrec_delay_state_q <= scaled;  // R19
      recursive_wide_state_q <= recur_next;  // R20
    end
  end

  // Frame and sub-segment counters advance per accepted sample
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_q <= 8'h00;
      sub_idx_q <= 6'h00;
    end else if (take) begin
      idx_q <= last ? 8'h00 : idx_q + 8'h01;  // R15
      sub_idx_q <= (last || sub_idx_q == spp_pkg::SUBSEG_LAST) ? 6'h00 : sub_idx_q + 6'h01;  // R15
    end
  end

  // Track whether the frame so far is all homing samples
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      home_q <= 1'b1;
    end else if (take) begin
      home_q <= last ? 1'b1 : home_q && (in_sample == spp_pkg::HOME_PATTERN);  // R23
    end
  end

  // Single output slot; a new sample may enter as the old one leaves
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid_q <= 1'b0;
      out_sample_q <= 16'h0000;
      frame_end_q <= 1'b0;
      subseg_end_q <= 1'b0;
    end else if (take) begin
      out_valid_q <= 1'b1;
      out_sample_q <= filt_out;
      frame_end_q <= last;  // R24
      subseg_end_q <= last || sub_idx_q == spp_pkg::SUBSEG_LAST;  // R15
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  assign out_valid = out_valid_q;
  assign out_sample = out_sample_q;
  assign out_frame_end = frame_end_q && out_valid_q;
  assign out_subseg_end = subseg_end_q && out_valid_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence homing_end_s;
    homing_done;
  endsequence

  sequence states_zero_s;
    nonrec_delay_state_q == 16'h0000 && recursive_wide_state_q == 32'h00000000;
  endsequence

  home_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) homing_end_s |=> states_zero_s)  // R23
    else $error("homing frame did not clear states");

  delay_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take && !homing_done |=> nonrec_delay_state_q == $past(scaled))  // R19
    else $error("delay state not loaded with scaled input");

  out_track_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take |=> out_valid && out_sample == $past(filt_out))  // R21
    else $error("filtered sample not presented");

  frame_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take && idx_q == 8'(FRAME_SAMPLES - 1) |=> out_frame_end)  // R24
    else $error("frame end missing on last sample");

  no_early_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take && idx_q != 8'(FRAME_SAMPLES - 1) |=> !out_frame_end)  // R24
    else $error("frame end on wrong sample");

  hold_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    out_valid && !out_ready |=> out_valid && $stable(out_sample))  // R24
    else $error("output dropped under back-pressure");

  state_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !take |=> $stable(recursive_wide_state_q) && $stable(nonrec_delay_state_q))  // R22
    else $error("filter state changed without sample");

  lsb_ignore_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    scaled[1:0] == 2'h0 && scaled[15:14] == {2{scaled[15]}})  // R18 R16
    else $error("downscaled sample out of form");

  alu_sat_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    alu_op == 4'h2 && alu_a[15:0] == 16'h8000 && alu_b[15:0] == 16'h8000 |=> alu_y == 32'h00007FFF)  // R3
    else $error("min squared multiply not saturated");

endmodule

/* test/spp_sample_source.sv */
// Model of the linear sample source feeding the pre-processing block
`timescale 1ns/1ps
module spp_sample_source (
  input wire logic sys_clk,
  input wire logic in_ready,
  output logic in_valid,
  output logic [15:0] in_sample
);
  // ****************************************************************
  // Handshake driver
  // ****************************************************************
  // Idle source at time zero
  initial begin
    in_valid = 1'b0;
    in_sample = 16'hFFFF;
  end

  // Offer one word after a gap and hold it until it is taken
  task automatic send(input logic [15:0] word, input int gap, output logic ok);
    int n;
    ok = 1'b0;
    if (gap > 0) begin
      in_valid = 1'b0;
      in_sample = ~in_sample;  // Released bus shows no stale word
      repeat (gap) @(negedge sys_clk);
    end
    in_valid = 1'b1;
    in_sample = word;
    for (n = 0; n < 200 && !ok; n++) begin
      @(posedge sys_clk);
      ok = (in_ready === 1'b1);
    end
    @(negedge sys_clk);
  endtask

  // Drop the offer between frames
  task automatic release_bus();
    in_valid = 1'b0;
    in_sample = ~in_sample;
  endtask
endmodule

/* test/test_speech_preprocess_fixed_point.sv */
// Self-checking bench for the speech pre-processing block
`timescale 1ns/1ps
module test_speech_preprocess_fixed_point;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;  // Held high from time zero
  logic in_valid;
  logic in_ready;
  logic [15:0] in_sample;
  logic out_valid;
  logic out_ready = 1'b1;
  logic [15:0] out_sample;
  logic out_frame_end;
  logic out_subseg_end;
  logic [3:0] alu_op = 4'h0;
  logic [31:0] alu_a = 32'h00000000;
  logic [31:0] alu_b = 32'h00000000;
  logic [31:0] alu_y;
  logic div_start = 1'b0;
  logic [15:0] div_num = 16'h0001;
  logic [15:0] div_den = 16'h0001;
  logic div_busy;
  logic div_done;
  logic [15:0] div_quot;
  logic stall_on = 1'b0;  // Downstream back-pressure enable
  logic [2:0] cyc = 3'h0;  // Free cycle count for stalls
  int miscompares = 0;
  int total_checks = 0;
  longint dly_m = 0;  // Expected delay state
  longint lz2_m = 0;  // Expected wide state
  logic [17:0] exp_q[$];  // Expected frame end, sub-segment end, sample

  // ****************************************************************
  // Instances and clock
  // ****************************************************************
  spp_top #(.FRAME_SAMPLES(160)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .in_valid(in_valid),
    .in_ready(in_ready), .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready),
    .out_sample(out_sample), .out_frame_end(out_frame_end), .out_subseg_end(out_subseg_end),
    .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_y(alu_y), .div_start(div_start),
    .div_num(div_num), .div_den(div_den), .div_busy(div_busy), .div_done(div_done), .div_quot(div_quot));

  spp_sample_source i_src (.sys_clk(sys_clk), .in_ready(in_ready), .in_valid(in_valid), .in_sample(in_sample));

  // 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Downstream stalls three cycles in eight when enabled
  always @(negedge sys_clk) begin
    cyc <= cyc + 3'h1;
    out_ready <= !stall_on || (cyc > 3'h2);
  end

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Saturate to a symmetric-plus-one range
  function automatic longint sat(input longint v, input longint hi);
    return (v > hi) ? hi : ((v < -hi - 1) ? -hi - 1 : v);
  endfunction

  // One sample through the expected filter
  task automatic model_step(input logic [15:0] raw, output logic [15:0] y);
    longint so, dif, ls2, msp, lsp;
    so = (longint'($signed(raw)) >>> 3) <<< 2;
    dif = sat(so - dly_m, 32767);
    dly_m = so;
    msp = lz2_m >>> 15;
    msp = longint'($signed(msp[15:0]));
    lsp = lz2_m - (msp <<< 15);
    ls2 = sat((dif <<< 15) + ((lsp * 32735 + 16384) >>> 15), 2147483647);
    lz2_m = sat(msp * 32735 + ls2, 2147483647);
    y = 16'(sat(lz2_m + 16384, 2147483647) >>> 15);
  endtask

  // Every accepted output is compared with the next expectation
  always @(posedge sys_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("output count", 32'h1, 32'h0);
      end else begin
        check("output word", {out_frame_end, out_subseg_end, out_sample}, exp_q.pop_front());
      end
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset and confirm idle outputs
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("valid in reset", out_valid, 32'h0);
    check("ready in reset", in_ready, 32'h1);
    check("alu in reset", alu_y, 32'h0);
    sys_rst = 1'b0;
    dly_m = 0;
    lz2_m = 0;
    exp_q.delete();
  endtask

  // One primitive operation, result one cycle later
  task automatic alu_chk(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b, input logic [31:0] e);
    @(negedge sys_clk);
    alu_op = op;
    alu_a = a;
    alu_b = b;
    @(negedge sys_clk);
    check("alu result", alu_y, e);
  endtask

  // Division with a refused restart while busy
  task automatic div_chk(input logic [15:0] n, input logic [15:0] d, input logic [15:0] e);
    int c;
    @(negedge sys_clk);
    div_start = 1'b1;
    div_num = n;
    div_den = d;
    @(negedge sys_clk);
    c = 1;
    check("divider busy", div_busy, 32'h1);
    while (div_done !== 1'b1 && c < 40) begin
      div_start = (c == 5);
      div_num = 16'h0001;
      div_den = 16'h0002;
      @(negedge sys_clk);
      c++;
    end
    check("divider latency", c, 32'd16);
    check("divider quotient", div_quot, e);
    @(negedge sys_clk);
    check("divider done pulse", div_done, 32'h0);
    check("divider quotient held", div_quot, e);
  endtask

  // A frame of 160 samples: 0 data, 1 homing, 2 homing with one odd word
  task automatic run_frame(input int kind, input int pat);
    logic [15:0] raw;
    logic [15:0] y;
    logic ok;
    logic home;
    int k;
    int n;
    home = 1'b1;
    stall_on = (pat % 2 == 1);
    for (k = 0; k < 160; k++) begin
      if (kind == 0) begin
        raw = {13'(((k * 1237 + pat * 3001) % 8192) - 4096), 3'(k)};
      end else begin
        raw = (kind == 2 && k == 77) ? 16'h000F : 16'h0008;
      end
      home = home && (raw == 16'h0008);
      model_step(raw, y);
      exp_q.push_back({k == 159, k % 40 == 39, y});
      i_src.send(raw, (k % 11 == 3) ? 2 : 0, ok);
      if (!ok) begin
        check("source stalled", 32'h0, 32'h1);
        finish_test();
      end
    end
    if (home) begin
      dly_m = 0;
      lz2_m = 0;
    end
    i_src.release_bus();
    for (n = 0; n < 100 && exp_q.size() > 0; n++) @(negedge sys_clk);
    check("frame drained", exp_q.size(), 32'h0);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    do_reset();
    alu_chk(4'h0, 32'h00007FFF, 32'h00000001, 32'h00007FFF);
    alu_chk(4'h0, 32'hFFFF8000, 32'hFFFFFFFF, 32'hFFFF8000);
    alu_chk(4'h1, 32'hFFFF8000, 32'h00000001, 32'hFFFF8000);
    alu_chk(4'h1, 32'h00007FFF, 32'hFFFFFFFF, 32'h00007FFF);
    alu_chk(4'h2, 32'h00008000, 32'h00008000, 32'h00007FFF);
    alu_chk(4'h2, 32'hFFFFFFFF, 32'h00000001, 32'hFFFFFFFF);
    alu_chk(4'h3, 32'h00008000, 32'h00008000, 32'h00007FFF);
    alu_chk(4'h3, 32'h00004000, 32'h00000001, 32'h00000001);
    alu_chk(4'h3, 32'hFFFFFFFF, 32'h00000001, 32'h00000000);
    alu_chk(4'h4, 32'h00008000, 32'h00000000, 32'h00007FFF);
    alu_chk(4'h4, 32'h0000FFFB, 32'h00000000, 32'h00000005);
    alu_chk(4'h5, 32'h00004000, 32'h00004000, 32'h20000000);
    alu_chk(4'h5, 32'h0000FFFF, 32'h00000003, 32'hFFFFFFFA);
    alu_chk(4'h6, 32'h7FFFFFFF, 32'h00000001, 32'h7FFFFFFF);
    alu_chk(4'h6, 32'h80000000, 32'hFFFFFFFF, 32'h80000000);
    alu_chk(4'h7, 32'h80000000, 32'h00000001, 32'h80000000);
    alu_chk(4'h7, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'h7FFFFFFF);
    alu_chk(4'h8, 32'h00000003, 32'h00000004, 32'h00000030);
    alu_chk(4'h8, 32'hF0000000, 32'hFFFFFFFC, 32'hFF000000);
    alu_chk(4'hA, 32'h0000FF80, 32'hFFFFFFFC, 32'hFFFFFFF8);
    alu_chk(4'h9, 32'h80000000, 32'h00000004, 32'hF8000000);
    alu_chk(4'h9, 32'h00000001, 32'hFFFFFFFD, 32'h00000008);
    alu_chk(4'hB, 32'h00008000, 32'h00000003, 32'hFFFFF000);
    alu_chk(4'hB, 32'h00000005, 32'hFFFFFFFE, 32'h00000014);
    alu_chk(4'hC, 32'h12348001, 32'h00000000, 32'hFFFF8001);
    alu_chk(4'hD, 32'h1234ABCD, 32'h00000000, 32'hFFFFABCD);
    alu_chk(4'hD, 32'hFFFF1234, 32'h00000000, 32'h00001234);
    alu_chk(4'hE, 32'h12345678, 32'h00000001, 32'h00000000);
    div_chk(16'h0001, 16'h0003, 16'h2AAA);
    div_chk(16'h0005, 16'h0005, 16'h7FFF);
    div_chk(16'h0001, 16'h7FFF, 16'h0001);
    div_chk(16'h0003, 16'h0004, 16'h6000);
    run_frame(0, 1);
    run_frame(1, 0);
    run_frame(0, 2);
    run_frame(2, 0);
    run_frame(0, 3);
    do_reset();
    run_frame(0, 4);
    finish_test();
  end
endmodule
